/* File: hw/dsm_pkg.sv */
/*
  constants, source bundle and state record of the data signal modulator.
  assumes: one 125 mhz clock; registers reached over apb, one byte per word.
*/
package dsm_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTL0    = 8'h00;
  localparam logic [7:0]  OFS_CTL1    = 8'h04;
  localparam logic [7:0]  OFS_MSRC    = 8'h08;
  localparam logic [7:0]  OFS_HIGH_TIME_CARRIER    = 8'h0c;
  localparam logic [7:0]  OFS_LOW_TIME_CARRIER    = 8'h10;

  // modulation_control bit positions
  localparam int unsigned B_ON        = 7;
  localparam int unsigned B_OUT       = 5;
  localparam int unsigned B_OINV      = 4;
  localparam int unsigned B_SWBIT     = 0;
  // carrier_control bit positions
  localparam int unsigned B_HINV      = 5;
  localparam int unsigned B_HSYNC     = 4;
  localparam int unsigned B_LINV      = 1;
  localparam int unsigned B_LSYNC     = 0;
  localparam int unsigned MS_W        = 5;
  localparam int unsigned CS_W        = 4;

  localparam logic        CTL_RST     = 1'b0;
  localparam logic [4:0]  MS_RST      = 5'h00;
  localparam logic [3:0]  CS_RST      = 4'h0;

  // modulator source codes
  localparam logic [4:0]  MS_PIN      = 5'h00;
  localparam logic [4:0]  MS_SWBIT    = 5'h01;
  localparam logic [4:0]  MS_CCP1     = 5'h02;
  localparam logic [4:0]  MS_PWM1     = 5'h07;
  localparam logic [4:0]  MS_NCO      = 5'h09;
  localparam logic [4:0]  MS_CMP1     = 5'h0a;
  localparam logic [4:0]  MS_CLC1     = 5'h0c;
  localparam logic [4:0]  MS_UDT      = 5'h10;
  localparam logic [4:0]  MS_UTX      = 5'h11;
  localparam logic [4:0]  MS_SPI1     = 5'h12;
  localparam logic [4:0]  MS_LAST     = 5'h13;

  // carrier source codes
  localparam logic [3:0]  CS_PIN      = 4'h0;
  localparam logic [3:0]  CS_SYSCLK   = 4'h1;
  localparam logic [3:0]  CS_FOSC     = 4'h2;
  localparam logic [3:0]  CS_REF      = 4'h3;
  localparam logic [3:0]  CS_CCP1     = 4'h4;
  localparam logic [3:0]  CS_PWM1     = 4'h9;
  localparam logic [3:0]  CS_NCO      = 4'hb;
  localparam logic [3:0]  CS_CLC1     = 4'hc;

  typedef struct packed {
    logic       mod_pin;             // modulator_signal pin
    logic       high_time_carrier_pin;            // high_time_carrier pin
    logic       low_time_carrier_pin;            // low_time_carrier pin
    logic       fast_osc;            // fast_internal_osc
    logic       ref_clk;             // reference_clock_out
    logic [4:0] capture_compare_pwm;                 // capture_compare_pwm 5..1
    logic [1:0] pwm;                 // pwm units 2..1
    logic       numeric_oscillator;                 // numeric_oscillator
    logic [1:0] cmp;                 // comparators 2..1
    logic [3:0] logic_cell;                 // logic_cell 4..1
    logic       uart_dt;             // async_serial_port data
    logic       uart_txck;           // async_serial_port tx/clock
    logic [1:0] spi_sdo;             // sync_serial_port data 2..1
  } dsm_src_t;

  typedef struct packed {
    logic            module_on_bit;
    logic            output_invert_bit;
    logic            software_mod_bit;
    logic            high_carrier_invert;
    logic            high_carrier_sync;
    logic            low_carrier_invert;
    logic            low_carrier_sync;
    logic [MS_W-1:0] mod_source_field;
    logic [CS_W-1:0] high_carrier_field;
    logic [CS_W-1:0] low_carrier_field;
    dsm_src_t        sync1;
    dsm_src_t        sync2;
    logic            sysclk_div;
    logic            active_high;
    logic            prev_high;
    logic            prev_low;
    logic            output_state_bit;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } dsm_state_t;

endpackage : dsm_pkg

/* File: hw/dsm_top.sv */
/*
  data signal modulator: source selection, carrier polarity and sync,
  mixing, output polarity, apb register file.
  assumes: all sources are asynchronous to clk; apb master on clk;
  periph_reset is a synchronous reset from logic on clk.
*/
`timescale 1ns/10ps

module dsm_top (
  input  wire logic                        clk,            // system clock
  input  wire logic                        reset_n,        // async power-on reset
  input  wire logic                        periph_reset,   // sync reset, controls and output state, not selects
  input  wire logic                        psel,           // apb select
  input  wire logic                        penable,        // apb enable
  input  wire logic                        pwrite,         // apb direction
  input  wire logic [dsm_pkg::ADDR_W-1:0]  paddr,          // apb byte address
  input  wire logic [31:0]                 pwdata,         // apb write data
  input  wire logic [3:0]                  pstrb,          // apb byte strobes
  output logic      [31:0]                 prdata,         // apb read data
  output logic                             pready,         // apb ready
  output logic                             pslverr,        // apb error
  input  wire dsm_pkg::dsm_src_t           sources,        // raw source signals
  output logic                             mod_out         // modulated output pin
);

  dsm_pkg::dsm_state_t state;
  dsm_pkg::dsm_state_t next_state;

  // modulator source mux
  function automatic logic pick_mod(input dsm_pkg::dsm_src_t s,
                                    input logic [dsm_pkg::MS_W-1:0] code,
                                    input logic swbit);
    logic r;
    r = 1'b0;
    case (code)
      dsm_pkg::MS_PIN:   r = s.mod_pin;
      dsm_pkg::MS_SWBIT: r = swbit;
      dsm_pkg::MS_NCO:   r = s.numeric_oscillator;
      dsm_pkg::MS_UDT:   r = s.uart_dt;
      dsm_pkg::MS_UTX:   r = s.uart_txck;
      default: begin
        if (code >= dsm_pkg::MS_CCP1 && code < dsm_pkg::MS_PWM1) begin
          r = s.capture_compare_pwm[3'(code - dsm_pkg::MS_CCP1)];
        end else if (code >= dsm_pkg::MS_PWM1 && code < dsm_pkg::MS_NCO) begin
          r = s.pwm[1'(code - dsm_pkg::MS_PWM1)];
        end else if (code >= dsm_pkg::MS_CMP1 && code < dsm_pkg::MS_CLC1) begin
          r = s.cmp[1'(code - dsm_pkg::MS_CMP1)];
        end else if (code >= dsm_pkg::MS_CLC1 && code < dsm_pkg::MS_UDT) begin
          r = s.logic_cell[2'(code - dsm_pkg::MS_CLC1)];
        end else if (code >= dsm_pkg::MS_SPI1 && code <= dsm_pkg::MS_LAST) begin
          r = s.spi_sdo[1'(code - dsm_pkg::MS_SPI1)];
        end else begin
          r = 1'b0;
        end
      end
    endcase
    return r;
  endfunction : pick_mod

  // carrier source mux, shared by both carriers
  function automatic logic pick_car(input dsm_pkg::dsm_src_t s,
                                    input logic [dsm_pkg::CS_W-1:0] code,
                                    input logic pin,
                                    input logic sysclk);
    logic r;
    r = 1'b0;
    case (code)
      dsm_pkg::CS_PIN:    r = pin;
      dsm_pkg::CS_SYSCLK: r = sysclk;
      dsm_pkg::CS_FOSC:   r = s.fast_osc;
      dsm_pkg::CS_REF:    r = s.ref_clk;
      dsm_pkg::CS_NCO:    r = s.numeric_oscillator;
      default: begin
        if (code >= dsm_pkg::CS_CCP1 && code < dsm_pkg::CS_PWM1) begin
          r = s.capture_compare_pwm[3'(code - dsm_pkg::CS_CCP1)];
        end else if (code >= dsm_pkg::CS_PWM1 && code < dsm_pkg::CS_NCO) begin
          r = s.pwm[1'(code - dsm_pkg::CS_PWM1)];
        end else begin
          r = s.logic_cell[2'(code - dsm_pkg::CS_CLC1)];
        end
      end
    endcase
    return r;
  endfunction : pick_car

  // read view of one register, unimplemented bits zero
  function automatic logic [32:0] read_reg(input dsm_pkg::dsm_state_t st,
                                           input logic [dsm_pkg::ADDR_W-1:0] a);
    logic [31:0] d;
    logic        hit;
    d   = '0;
    hit = 1'b1;
    case (a)
      dsm_pkg::OFS_CTL0: begin
        d[dsm_pkg::B_ON]    = st.module_on_bit;
        d[dsm_pkg::B_OUT]   = st.output_state_bit;
        d[dsm_pkg::B_OINV]  = st.output_invert_bit;
        d[dsm_pkg::B_SWBIT] = st.software_mod_bit;
      end
      dsm_pkg::OFS_CTL1: begin
        d[dsm_pkg::B_HINV]  = st.high_carrier_invert;
        d[dsm_pkg::B_HSYNC] = st.high_carrier_sync;
        d[dsm_pkg::B_LINV]  = st.low_carrier_invert;
        d[dsm_pkg::B_LSYNC] = st.low_carrier_sync;
      end
      dsm_pkg::OFS_MSRC: d[dsm_pkg::MS_W-1:0] = st.mod_source_field;
      dsm_pkg::OFS_HIGH_TIME_CARRIER: d[dsm_pkg::CS_W-1:0] = st.high_carrier_field;
      dsm_pkg::OFS_LOW_TIME_CARRIER: d[dsm_pkg::CS_W-1:0] = st.low_carrier_field;
      default:           hit = 1'b0;
    endcase
    return {hit, d};
  endfunction : read_reg

  logic [32:0] rd_view;
  logic        setup_phase;
  logic        wr_take;
  logic        mod_level;
  logic        car_high;
  logic        car_low;
  logic        fall_high;
  logic        fall_low;
  logic        next_active;
  logic        mixed;

  always_comb begin
    next_state = state;

    // two-flop synchronisers; only sync2 feeds logic
    next_state.sync1 = sources;
    next_state.sync2 = state.sync1;
    // stand-in for the system clock as a carrier: clk divided by two
    next_state.sysclk_div = ~state.sysclk_div;

    // selected and polarity-adjusted carriers, grounded while off
    car_high = pick_car(state.sync2, state.high_carrier_field,
                        state.sync2.high_time_carrier_pin, state.sysclk_div)
               ^ state.high_carrier_invert;
    car_low  = pick_car(state.sync2, state.low_carrier_field,
                        state.sync2.low_time_carrier_pin, state.sysclk_div)
               ^ state.low_carrier_invert;
    if (!state.module_on_bit) begin
      car_high = 1'b0;
      car_low  = 1'b0;
      mod_level = state.software_mod_bit;
    end else begin
      mod_level = pick_mod(state.sync2, state.mod_source_field,
                           state.software_mod_bit);
    end

    fall_high = state.prev_high & ~car_high;
    fall_low  = state.prev_low  & ~car_low;
    next_state.prev_high = car_high;
    next_state.prev_low  = car_low;

    // active carrier follows the modulator, held back by sync
    next_active = state.active_high;
    if (mod_level != state.active_high) begin
      if (state.active_high) begin
        if (!state.high_carrier_sync || fall_high) begin
          next_active = 1'b0;
        end
      end else begin
        if (!state.low_carrier_sync || fall_low) begin
          next_active = 1'b1;
        end
      end
    end
    next_state.active_high = next_active;

    // carrier gated by the switched modulator
    mixed = (next_active & car_high) | (~next_active & car_low);
    if (state.module_on_bit) begin
      next_state.output_state_bit = mixed ^ state.output_invert_bit;
    end else begin
      next_state.output_state_bit = 1'b0;
    end

    // apb: ready one cycle after setup, so zero wait states
    setup_phase = psel & ~penable;
    rd_view     = read_reg(state, paddr);
    next_state.pready = setup_phase;
    if (setup_phase) begin
      next_state.pslverr = ~rd_view[32];
      next_state.prdata  = pwrite ? '0 : rd_view[31:0];
    end
    wr_take = psel & penable & state.pready & pwrite & rd_view[32] & pstrb[0];
    if (wr_take) begin
      case (paddr)
        dsm_pkg::OFS_CTL0: begin
          next_state.module_on_bit     = pwdata[dsm_pkg::B_ON];
          next_state.output_invert_bit = pwdata[dsm_pkg::B_OINV];
          next_state.software_mod_bit  = pwdata[dsm_pkg::B_SWBIT];
        end
        dsm_pkg::OFS_CTL1: begin
          next_state.high_carrier_invert = pwdata[dsm_pkg::B_HINV];
          next_state.high_carrier_sync   = pwdata[dsm_pkg::B_HSYNC];
          next_state.low_carrier_invert  = pwdata[dsm_pkg::B_LINV];
          next_state.low_carrier_sync    = pwdata[dsm_pkg::B_LSYNC];
        end
        dsm_pkg::OFS_MSRC: next_state.mod_source_field   = pwdata[dsm_pkg::MS_W-1:0];
        dsm_pkg::OFS_HIGH_TIME_CARRIER: next_state.high_carrier_field = pwdata[dsm_pkg::CS_W-1:0];
        dsm_pkg::OFS_LOW_TIME_CARRIER: next_state.low_carrier_field  = pwdata[dsm_pkg::CS_W-1:0];
        default: begin
        end
      endcase
    end

    // other resets clear controls, selects survive
    if (periph_reset) begin
      next_state.module_on_bit       = dsm_pkg::CTL_RST;
      next_state.output_invert_bit   = dsm_pkg::CTL_RST;
      next_state.software_mod_bit    = dsm_pkg::CTL_RST;
      next_state.high_carrier_invert = dsm_pkg::CTL_RST;
      next_state.high_carrier_sync   = dsm_pkg::CTL_RST;
      next_state.low_carrier_invert  = dsm_pkg::CTL_RST;
      next_state.low_carrier_sync    = dsm_pkg::CTL_RST;
      next_state.output_state_bit    = 1'b0;
      next_state.active_high         = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                    <= '0;
      state.mod_source_field   <= dsm_pkg::MS_RST;
      state.high_carrier_field <= dsm_pkg::CS_RST;
      state.low_carrier_field  <= dsm_pkg::CS_RST;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;
  assign mod_out = state.output_state_bit;

endmodule : dsm_top

/* File: verif/dsm_props.sv */
/* port checker of the data signal modulator top.
   assumes: bound into dsm_top; one clock, async reset_n. */
`timescale 1ns/10ps
module dsm_props (
  input wire logic              clk,          // system clock
  input wire logic              reset_n,      // async reset
  input wire logic              periph_reset, // sync control reset
  input wire logic              psel,         // apb select
  input wire logic              penable,      // apb enable
  input wire logic              pwrite,       // apb direction
  input wire logic [7:0]        paddr,        // apb address
  input wire logic [31:0]       pwdata,       // apb write data
  input wire logic [3:0]        pstrb,        // apb strobes
  input wire logic [31:0]       prdata,       // apb read data
  input wire logic              pready,       // apb ready
  input wire logic              pslverr,      // apb error
  input wire dsm_pkg::dsm_src_t sources,      // raw sources
  input wire logic              mod_out       // modulated pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic on_q;
  logic acc;
  assign acc = psel && penable && pready;
  // shadow of module_on_bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) on_q <= 1'b0;
    else if (periph_reset) on_q <= 1'b0;
    else if (acc && pwrite && pstrb[0] && paddr == dsm_pkg::OFS_CTL0) on_q <= pwdata[7];
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (acc && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctl1_reserved: assert property (acc && !pwrite && paddr == dsm_pkg::OFS_CTL1 |->
    prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00)
    else $error("carrier control reserved bits set");
  a_status_mirror: assert property (acc && !pwrite && paddr == dsm_pkg::OFS_CTL0 |->
    prdata[5] == $past(mod_out) && prdata[6] == 1'b0 && prdata[3:1] == 3'b000)
    else $error("status bit differs from pin");
  a_off_quiet: assert property (!on_q |=> !mod_out)
    else $error("output active while disabled");
  a_periph_clear: assert property (periph_reset |=> !mod_out && !on_q)
    else $error("output not cleared by reset");
endmodule : dsm_props

bind dsm_top dsm_props dsm_props_i (.clk(clk), .reset_n(reset_n),
  .periph_reset(periph_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sources(sources), .mod_out(mod_out));

/* File: verif/dsm_src_model.sv */
/* model of the on-chip peripherals and pins feeding the modulator.
   assumes: bench sets static levels; bits in run toggle as clocks. */
`timescale 1ns/10ps
module dsm_src_model #(
  parameter int unsigned HALF = 4  // toggle half period in cycles
) (
  input  wire logic              clk,     // system clock
  input  wire logic              reset_n, // async reset
  input  wire dsm_pkg::dsm_src_t levels,  // static levels
  input  wire dsm_pkg::dsm_src_t run,     // toggling bits
  output dsm_pkg::dsm_src_t      sources  // to the modulator
);
  logic [7:0] cnt;
  logic       ph;
  // every source, capture units included, shows its static level xored with the shared toggle where its run bit is set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt     <= 8'h00;
      ph      <= 1'b0;
      sources <= '0;
    end else begin
      cnt     <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
      ph      <= (cnt == 8'(HALF - 1)) ? ~ph : ph;
      sources <= levels ^ (run & {$bits(dsm_pkg::dsm_src_t){ph}});
    end
  end
endmodule : dsm_src_model

/* File: verif/test_data_signal_modulator.sv */
/* self-checking bench of the data signal modulator.
   assumes: dsm_top, dsm_src_model and dsm_props are compiled before. */
`timescale 1ns/10ps
module test_data_signal_modulator;
  logic              clk, reset_n, periph_reset, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              pready, pslverr, mod_out, er, a, e;
  dsm_pkg::dsm_src_t lv, run, src;
  int                error_cnt, checked;
  logic [7:0]        adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [7:0]        msk [5] = '{8'hb1, 8'h33, 8'h1f, 8'h0f, 8'h0f};

  dsm_top dsm_top_i (.clk(clk), .reset_n(reset_n), .periph_reset(periph_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sources(src), .mod_out(mod_out));
  dsm_src_model dsm_src_model_i (.clk(clk), .reset_n(reset_n), .levels(lv), .run(run),
    .sources(src));

  always #4 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // look between edges: outputs then hold what the next edge samples
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic chk_out(input logic ex);
    settle();
    @(negedge clk);
    check("mod_out", {31'h0, ex}, {31'h0, mod_out});
  endtask : chk_out

  function automatic dsm_pkg::dsm_src_t mod_hot(input int c);
    dsm_pkg::dsm_src_t s;
    s = '0;
    if (c == 0) s.mod_pin = 1'b1;
    else if (c >= 2 && c <= 6) s.capture_compare_pwm[c-2] = 1'b1;
    else if (c == 7 || c == 8) s.pwm[c-7] = 1'b1;
    else if (c == 9) s.numeric_oscillator = 1'b1;
    else if (c == 10 || c == 11) s.cmp[c-10] = 1'b1;
    else if (c >= 12 && c <= 15) s.logic_cell[c-12] = 1'b1;
    else if (c == 16) s.uart_dt = 1'b1;
    else if (c == 17) s.uart_txck = 1'b1;
    else if (c == 18 || c == 19) s.spi_sdo[c-18] = 1'b1;
    return s;
  endfunction : mod_hot

  function automatic dsm_pkg::dsm_src_t car_hot(input int c, input bit low);
    dsm_pkg::dsm_src_t s;
    s = '0;
    if (c == 0 && low) s.low_time_carrier_pin = 1'b1;
    else if (c == 0) s.high_time_carrier_pin = 1'b1;
    else if (c == 2) s.fast_osc = 1'b1;
    else if (c == 3) s.ref_clk = 1'b1;
    else if (c >= 4 && c <= 8) s.capture_compare_pwm[c-4] = 1'b1;
    else if (c == 9 || c == 10) s.pwm[c-9] = 1'b1;
    else if (c == 11) s.numeric_oscillator = 1'b1;
    else if (c >= 12) s.logic_cell[c-12] = 1'b1;
    return s;
  endfunction : car_hot

  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end

  initial begin
    clk = 0; reset_n = 0; periph_reset = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h1; lv = '0; run = '0;
    error_cnt = 0; checked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      xfer(0, adr[k], 8'h00); check("reset value", 32'h0, rd);
      xfer(1, adr[k], 8'hff);
      xfer(0, adr[k], 8'h00); check("read back", {24'h0, msk[k]}, rd);
    end
    xfer(0, 8'h14, 8'h00); check("unmapped", 32'h0, rd);
    check("unmapped err", 32'h1, {31'h0, er});
    @(posedge clk) periph_reset <= 1'b1;
    @(posedge clk) periph_reset <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      xfer(0, adr[k], 8'h00); check("after reset", {24'h0, k < 2 ? 8'h0 : msk[k]}, rd);
    end
    // disabled: inverted and fed, still quiet
    xfer(1, 8'h00, 8'h11); run = '1; lv = '1;
    repeat (20) begin
      @(negedge clk); check("off", 32'h0, {31'h0, mod_out});
    end
    run = '0;
    xfer(1, 8'h08, 8'h01); xfer(1, 8'h0c, 8'h00); xfer(1, 8'h10, 8'h00);
    for (int i = 0; i < 64; i++) begin
      lv = '0; lv.high_time_carrier_pin = i[1]; lv.low_time_carrier_pin = i[2];
      xfer(1, 8'h04, {2'b00, i[3], 3'b000, i[4], 1'b0});
      xfer(1, 8'h00, {3'b100, i[5], 3'b000, i[0]});
      e = (i[0] ? i[1] ^ i[3] : i[2] ^ i[4]) ^ i[5];
      chk_out(e);
      xfer(0, 8'h00, 8'h00); check("status", {24'h0, 2'b10, e, i[5], 3'b0, i[0]}, rd);
    end
    xfer(1, 8'h04, 8'h00); xfer(1, 8'h00, 8'h80);
    for (int c = 0; c < 32; c++) begin
      xfer(1, 8'h08, 8'(c));
      lv = mod_hot(c); lv.high_time_carrier_pin = 1'b1; chk_out(c < 20 && c != 1);
      lv = ~mod_hot(c); lv.high_time_carrier_pin = 1'b1; lv.low_time_carrier_pin = 1'b0; chk_out(1'b0);
    end
    xfer(1, 8'h08, 8'h01);
    for (int low = 0; low < 2; low++) begin
      xfer(1, 8'h00, {7'h40, low == 0});
      for (int c = 0; c < 16; c++) begin
        xfer(1, low ? 8'h10 : 8'h0c, 8'(c));
        if (c == 1) begin
          settle();
          @(negedge clk) a = mod_out;
          @(negedge clk); check("clk carrier", {31'h0, ~a}, {31'h0, mod_out});
        end else begin
          lv = car_hot(c, low); chk_out(1'b1);
          lv = ~car_hot(c, low); chk_out(1'b0);
        end
      end
    end
    xfer(1, 8'h08, 8'h00); xfer(1, 8'h0c, 8'h00); xfer(1, 8'h10, 8'h00);
    xfer(1, 8'h04, 8'h10); lv = '0; lv.mod_pin = 1'b1; lv.high_time_carrier_pin = 1'b1;
    chk_out(1'b1);
    lv.mod_pin = 1'b0; repeat (10) @(posedge clk); chk_out(1'b1);
    lv.high_time_carrier_pin = 1'b0; chk_out(1'b0);
    lv.high_time_carrier_pin = 1'b1; chk_out(1'b0);
    xfer(1, 8'h04, 8'h00); lv.mod_pin = 1'b1; chk_out(1'b1);
    lv.mod_pin = 1'b0; chk_out(1'b0);
    xfer(1, 8'h04, 8'h01); lv = '0; lv.low_time_carrier_pin = 1'b1;
    chk_out(1'b1);
    lv.mod_pin = 1'b1; repeat (10) @(posedge clk); chk_out(1'b1);
    lv.low_time_carrier_pin = 1'b0; chk_out(1'b0);
    lv.low_time_carrier_pin = 1'b1; chk_out(1'b0);
    complete_run();
  end
endmodule : test_data_signal_modulator
